// ==== logic/pwc_consts.svh ====
/*
 * Constants of the power and wake control register block: the register
 * offset, field positions, reset values and the wake pulse timing.
 * Assumes it is included by bare name by every design file that needs it.
 */
//
// Contract
// - word at 084h, always readable, even not ready
// - energy status bits 17/16 set, write-one clear
// - energy status stays set while phy event holds
// - energy enable drives pin per enable and mode
// - energy enable also raises wake interrupt
// - bit 10 resets virtual phy, self clears
// - writes to bit 10 ignored while high
// - bit 6 selects open-drain or push-pull
// - open-drain ignores polarity, active low
// - bit 5 net wake status, source-held clear
// - bit 3 zero pulses 50ms, one static
// - pin drops when status or enable cleared
// - bit 2 polarity in push-pull mode
// - immune fields survive soft reset
// - bit 1 enables pin, not interrupt
// - bit 0 shows device ready
//

`ifndef PWC_CONSTS_SVH
`define PWC_CONSTS_SVH

`define PWC_ADDR_W 12
`define PWC_OFF_POWER_WAKE_CONTROL 12'h084
`define PWC_WORD_ZERO 32'h0000_0000

`define PWC_BIT_ED_STS_P2 17
`define PWC_BIT_ED_STS_P1 16
`define PWC_BIT_ED_EN_P2 15
`define PWC_BIT_ED_EN_P1 14
`define PWC_BIT_VIRTUAL_PHY_RESET 10
`define PWC_BIT_NET_WAKE_EN 9
`define PWC_BIT_BUF_TYPE 6
`define PWC_BIT_NET_WAKE_STS 5
`define PWC_BIT_IND_MODE 3
`define PWC_BIT_POLARITY 2
`define PWC_BIT_PIN_EN 1
`define PWC_BIT_READY 0

`define PWC_RST_BIT 1'b0

`define PWC_CLK_MHZ 200
`define PWC_PULSE_MS 50
`define PWC_PULSE_CYCLES (`PWC_PULSE_MS * `PWC_CLK_MHZ * 1000)
`define PWC_CNT_W 24
`define PWC_CNT_ZERO 24'h00_0000

`endif

// ==== logic/pwc_pkg.sv ====
/*
 * Types shared by the power and wake control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwc_pkg;
	typedef logic [31:0] pwc_word_t;
	// indication mode encoding follows the field's value list
	typedef enum logic {PWC_IND_PULSE, PWC_IND_STATIC} pwc_ind_t;
	typedef enum logic {PWC_T_IDLE, PWC_T_RUN} pwc_tmr_state_t;
endpackage

// ==== logic/pwc_tmr_if.sv ====
/*
 * Carrier between the register block and its wake pulse timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface pwc_tmr_if;
	logic start;
	logic cancel;
	logic busy;
	modport ctrl (output start, output cancel, input busy);
	modport tmr (input start, input cancel, output busy);
endinterface

// ==== logic/pwc_sync.sv ====
/*
 * Two flip-flop synchroniser for the three wake event levels.
 * Assumes the inputs are slow levels from other domains.
 */
`timescale 1ns/1ps
`include "pwc_consts.svh"
module pwc_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] d,
	output logic [2:0] q
);
	logic [2:0] meta_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 3'h0;
			q <= 3'h0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // pwc_sync

// ==== logic/pwc_pulse_timer.sv ====
/*
 * Wake pin pulse timer: counts system clocks for the pulse length.
 * Assumes start is a one-clock request and cancel a level, both from the same domain.
 */
`timescale 1ns/1ps
`include "pwc_consts.svh"
module pwc_pulse_timer #(
	parameter int unsigned CYCLES = `PWC_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	pwc_tmr_if.tmr t
);
	import pwc_pkg::*;

	pwc_tmr_state_t state_q;
	logic [`PWC_CNT_W-1:0] cnt_q;

	assign t.busy = (state_q == PWC_T_RUN);

	// a new start restarts the full length; cancel wins over start
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= PWC_T_IDLE;
			cnt_q <= `PWC_CNT_ZERO;
		end else begin
			case (state_q)
			PWC_T_IDLE: begin
				if (t.start && !t.cancel) begin
					state_q <= PWC_T_RUN;
					cnt_q <= `PWC_CNT_W'(CYCLES - 1);
				end
			end
			PWC_T_RUN: begin
				if (t.cancel) begin
					state_q <= PWC_T_IDLE;
				end else if (t.start) begin
					cnt_q <= `PWC_CNT_W'(CYCLES - 1);
				end else if (cnt_q == `PWC_CNT_ZERO) begin
					state_q <= PWC_T_IDLE;
				end else begin
					cnt_q <= cnt_q - `PWC_CNT_W'(1);
				end
			end
			default: state_q <= PWC_T_IDLE;
			endcase
		end
	end
endmodule // pwc_pulse_timer

// ==== logic/pwc_top.sv ====
/*
 * Power and wake control register with energy-detect and network wake
 * status, per-source enables, the wake event pin driver and the
 * self-clearing virtual phy reset.
 * Assumes: event inputs are levels from other domains that stay high
 * until the source clears them; device_ready, vphy_released and
 * soft_rst come from logic on clk; the pad resolves pin level from
 * wake_pin_o and wake_pin_oe.
 */
`timescale 1ns/1ps
`include "pwc_consts.svh"
module pwc_top #(
	parameter int unsigned PULSE_CYCLES = `PWC_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic soft_rst,
	input wire logic [`PWC_ADDR_W-1:0] reg_addr,
	input wire pwc_pkg::pwc_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output pwc_pkg::pwc_word_t reg_rdata,
	input wire logic phy1_energy_event,
	input wire logic phy2_energy_event,
	input wire logic mac_wake_event,
	input wire logic device_ready,
	input wire logic vphy_released,
	output logic vphy_reset,
	output logic wake_pin_o,
	output logic wake_pin_oe,
	output logic wake_int_set
);
	import pwc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// helpers

	// a write-one clear cannot beat a source that still holds its event
	function automatic logic sticky_next(
		input logic cur,
		input logic src,
		input logic clr
	);
		sticky_next = src | (cur & ~clr);
	endfunction

	function automatic logic wbit(
		input pwc_word_t w,
		input int unsigned pos
	);
		wbit = w[pos];
	endfunction

	////////////////////////////////////////////////////////////////////
	// event synchronisers

	logic [2:0] ev_raw;
	logic [2:0] ev_s;
	logic ev_p2;
	logic ev_p1;
	logic ev_net;

	assign ev_raw = {phy2_energy_event, phy1_energy_event, mac_wake_event};

	pwc_sync u_sync (
		.clk (clk),
		.sys_rst (sys_rst),
		.d (ev_raw),
		.q (ev_s)
	);

	assign ev_p2 = ev_s[2];
	assign ev_p1 = ev_s[1];
	assign ev_net = ev_s[0];

	////////////////////////////////////////////////////////////////////
	// register decode

	logic wr_hit;
	logic rd_hit;

	// only one word is mapped; it never depends on readiness
	always_comb begin
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		if (reg_addr == `PWC_OFF_POWER_WAKE_CONTROL) begin
			wr_hit = reg_wr;
			rd_hit = reg_rd;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status bits

	logic ed_sts_p2_q;
	logic ed_sts_p1_q;
	logic net_wake_sts_q;
	logic clr_p2;
	logic clr_p1;
	logic clr_net;

	assign clr_p2 = wr_hit & wbit(reg_wdata, `PWC_BIT_ED_STS_P2);
	assign clr_p1 = wr_hit & wbit(reg_wdata, `PWC_BIT_ED_STS_P1);
	assign clr_net = wr_hit & wbit(reg_wdata, `PWC_BIT_NET_WAKE_STS);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ed_sts_p2_q <= `PWC_RST_BIT;
			ed_sts_p1_q <= `PWC_RST_BIT;
			net_wake_sts_q <= `PWC_RST_BIT;
		end else if (soft_rst) begin
			ed_sts_p2_q <= `PWC_RST_BIT;
			ed_sts_p1_q <= `PWC_RST_BIT;
			net_wake_sts_q <= `PWC_RST_BIT;
		end else begin
			ed_sts_p2_q <= sticky_next(ed_sts_p2_q, ev_p2, clr_p2);
			ed_sts_p1_q <= sticky_next(ed_sts_p1_q, ev_p1, clr_p1);
			net_wake_sts_q <= sticky_next(net_wake_sts_q, ev_net, clr_net);
		end
	end

	////////////////////////////////////////////////////////////////////
	// enables and mode bits cleared by soft reset

	logic ed_en_p2_q;
	logic ed_en_p1_q;
	logic net_wake_en_q;
	pwc_ind_t ind_mode_q;
	logic pin_en_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ed_en_p2_q <= `PWC_RST_BIT;
			ed_en_p1_q <= `PWC_RST_BIT;
			net_wake_en_q <= `PWC_RST_BIT;
			ind_mode_q <= PWC_IND_PULSE;
			pin_en_q <= `PWC_RST_BIT;
		end else if (soft_rst) begin
			ed_en_p2_q <= `PWC_RST_BIT;
			ed_en_p1_q <= `PWC_RST_BIT;
			net_wake_en_q <= `PWC_RST_BIT;
			ind_mode_q <= PWC_IND_PULSE;
			pin_en_q <= `PWC_RST_BIT;
		end else if (wr_hit) begin
			ed_en_p2_q <= wbit(reg_wdata, `PWC_BIT_ED_EN_P2);
			ed_en_p1_q <= wbit(reg_wdata, `PWC_BIT_ED_EN_P1);
			net_wake_en_q <= wbit(reg_wdata, `PWC_BIT_NET_WAKE_EN);
			ind_mode_q <= pwc_ind_t'(wbit(reg_wdata, `PWC_BIT_IND_MODE));
			pin_en_q <= wbit(reg_wdata, `PWC_BIT_PIN_EN);
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin buffer type and polarity, kept over soft reset

	logic buf_push_pull_q;
	logic polarity_high_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_push_pull_q <= `PWC_RST_BIT;
			polarity_high_q <= `PWC_RST_BIT;
		end else if (wr_hit) begin
			// soft_rst deliberately not looked at here
			buf_push_pull_q <= wbit(reg_wdata, `PWC_BIT_BUF_TYPE);
			polarity_high_q <= wbit(reg_wdata, `PWC_BIT_POLARITY);
		end
	end

	////////////////////////////////////////////////////////////////////
	// virtual phy reset

	logic virtual_phy_reset_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			virtual_phy_reset_q <= `PWC_RST_BIT;
		end else if (soft_rst) begin
			virtual_phy_reset_q <= `PWC_RST_BIT;
		end else if (virtual_phy_reset_q) begin
			// writes are ignored until the phy reports release
			if (vphy_released) begin
				virtual_phy_reset_q <= `PWC_RST_BIT;
			end
		end else if (wr_hit && wbit(reg_wdata, `PWC_BIT_VIRTUAL_PHY_RESET)) begin
			virtual_phy_reset_q <= 1'b1;
		end
	end

	assign vphy_reset = virtual_phy_reset_q;

	////////////////////////////////////////////////////////////////////
	// wake source arming and interrupt

	logic [2:0] armed;
	logic [2:0] armed_prev_q;
	logic trig;
	logic cond;
	logic int_set_q;

	// a source drives the pin only while its status and enable both hold
	assign armed = {ed_sts_p2_q & ed_en_p2_q,
		ed_sts_p1_q & ed_en_p1_q,
		net_wake_sts_q & net_wake_en_q};
	assign trig = |(armed & ~armed_prev_q);
	assign cond = |armed;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			armed_prev_q <= 3'h0;
		end else begin
			armed_prev_q <= armed;
		end
	end

	// the interrupt request ignores the pin enable
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			int_set_q <= `PWC_RST_BIT;
		end else begin
			int_set_q <= trig;
		end
	end

	assign wake_int_set = int_set_q;

	////////////////////////////////////////////////////////////////////
	// pulse timer

	pwc_tmr_if tmr ();

	assign tmr.start = trig & pin_en_q & (ind_mode_q == PWC_IND_PULSE);
	assign tmr.cancel = ~cond | ~pin_en_q;

	pwc_pulse_timer #(
		.CYCLES (PULSE_CYCLES)
	) u_timer (
		.clk (clk),
		.sys_rst (sys_rst),
		.t (tmr)
	);

	////////////////////////////////////////////////////////////////////
	// wake pin driver

	logic pin_active;
	logic pin_o_q;
	logic pin_oe_q;

	always_comb begin
		pin_active = 1'b0;
		if (pin_en_q && cond) begin
			if (ind_mode_q == PWC_IND_STATIC) begin
				pin_active = 1'b1;
			end else begin
				pin_active = tmr.busy;
			end
		end
	end

	// open-drain pulls low when active and floats otherwise
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_o_q <= `PWC_RST_BIT;
			pin_oe_q <= `PWC_RST_BIT;
		end else if (buf_push_pull_q) begin
			pin_o_q <= polarity_high_q ? pin_active : ~pin_active;
			pin_oe_q <= 1'b1;
		end else begin
			pin_o_q <= 1'b0;
			pin_oe_q <= pin_active;
		end
	end

	assign wake_pin_o = pin_o_q;
	assign wake_pin_oe = pin_oe_q;

	////////////////////////////////////////////////////////////////////
	// read back

	pwc_word_t rd_word;
	pwc_word_t rdata_q;

	always_comb begin
		rd_word = `PWC_WORD_ZERO;
		rd_word[`PWC_BIT_ED_STS_P2] = ed_sts_p2_q;
		rd_word[`PWC_BIT_ED_STS_P1] = ed_sts_p1_q;
		rd_word[`PWC_BIT_ED_EN_P2] = ed_en_p2_q;
		rd_word[`PWC_BIT_ED_EN_P1] = ed_en_p1_q;
		rd_word[`PWC_BIT_VIRTUAL_PHY_RESET] = virtual_phy_reset_q;
		rd_word[`PWC_BIT_NET_WAKE_EN] = net_wake_en_q;
		rd_word[`PWC_BIT_BUF_TYPE] = buf_push_pull_q;
		rd_word[`PWC_BIT_NET_WAKE_STS] = net_wake_sts_q;
		rd_word[`PWC_BIT_IND_MODE] = logic'(ind_mode_q);
		rd_word[`PWC_BIT_POLARITY] = polarity_high_q;
		rd_word[`PWC_BIT_PIN_EN] = pin_en_q;
		rd_word[`PWC_BIT_READY] = device_ready;
	end

	// unmapped reads and idle cycles return zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= `PWC_WORD_ZERO;
		end else if (rd_hit) begin
			rdata_q <= rd_word;
		end else begin
			rdata_q <= `PWC_WORD_ZERO;
		end
	end

	assign reg_rdata = rdata_q;

endmodule // pwc_top

// ==== tb/pwc_top_chk.sv ====
/*
 * Port checker for the power and wake control register block.
 * Assumes one clock and an asynchronous active high reset.
 */
`timescale 1ns/1ps
`include "pwc_consts.svh"
module pwc_chk #(
	parameter int unsigned PULSE_CYCLES = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic soft_rst,
	input wire logic [`PWC_ADDR_W-1:0] reg_addr,
	input wire pwc_pkg::pwc_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire pwc_pkg::pwc_word_t reg_rdata,
	input wire logic device_ready,
	input wire logic vphy_released,
	input wire logic vphy_reset,
	input wire logic wake_pin_o,
	input wire logic wake_pin_oe,
	input wire logic wake_int_set
);
	import pwc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////
	property p_rd_idle;
		!$past(reg_rd && reg_addr == 12'h084) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_rsv;
		(reg_rdata & 32'hFFFC_3990) == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved bit reads one");
	property p_ready;
		$past(reg_rd && reg_addr == 12'h084) && $stable(device_ready)
			|-> reg_rdata[0] == device_ready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready bit wrong");
	property p_vphy_set;
		reg_wr && reg_addr == 12'h084 && reg_wdata[10] && !vphy_reset
			&& !soft_rst && !vphy_released |=> vphy_reset;
	endproperty
	a_vphy_set: assert property (p_vphy_set)
		else $error("virtual phy reset not set");
	property p_vphy_clr;
		vphy_released && vphy_reset |=> !vphy_reset;
	endproperty
	a_vphy_clr: assert property (p_vphy_clr)
		else $error("virtual phy reset not cleared");
	property p_vphy_hold;
		vphy_reset && !vphy_released && !soft_rst |=> vphy_reset;
	endproperty
	a_vphy_hold: assert property (p_vphy_hold)
		else $error("virtual phy reset dropped by write");
	property p_od;
		!wake_pin_oe |-> !wake_pin_o;
	endproperty
	a_od: assert property (p_od)
		else $error("released pin carries a one");
	property p_int_pulse;
		wake_int_set |=> !wake_int_set;
	endproperty
	a_int_pulse: assert property (p_int_pulse)
		else $error("interrupt set longer than one cycle");
	c_vphy: cover property (vphy_reset ##1 !vphy_reset);
	c_int: cover property (wake_int_set);
	c_od: cover property (wake_pin_oe && !wake_pin_o);
endmodule // pwc_chk

bind pwc_top pwc_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_pwc_chk (.clk,
	.sys_rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .device_ready, .vphy_released, .vphy_reset, .wake_pin_o,
	.wake_pin_oe, .wake_int_set);

// ==== tb/pwc_host_model.sv ====
/*
 * Host side of the wake event line: the board pull-up and the wire.
 * Assumes the pad drives wake_pin_o only while wake_pin_oe is high.
 */
`timescale 1ns/1ps
module pwc_host_model (
	input wire logic wake_pin_o,
	input wire logic wake_pin_oe,
	output logic pin_level
);
	// released line floats up to the pull-up, so wired-or works
	assign pin_level = wake_pin_oe ? wake_pin_o : 1'b1;
endmodule // pwc_host_model

// ==== tb/test_wake_event_power_ctrl_reg.sv ====
/*
 * Self-checking bench for the power and wake control register block.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
module test_wake_event_power_ctrl_reg;
	import pwc_pkg::*;
	localparam int unsigned PC = 20;
	localparam logic [11:0] A = 12'h084;
	logic clk, sys_rst, soft_rst, reg_wr, reg_rd;
	logic device_ready, vphy_released, vphy_reset;
	logic wake_pin_o, wake_pin_oe, wake_int_set, pin_level;
	logic [11:0] reg_addr;
	logic [2:0] ev;
	pwc_word_t reg_wdata, reg_rdata, rv;
	int err_total, n_checks, pi;
	pwc_top #(.PULSE_CYCLES(PC)) u_pwc_top (.clk, .sys_rst, .soft_rst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.phy1_energy_event(ev[0]), .phy2_energy_event(ev[1]),
		.mac_wake_event(ev[2]), .device_ready, .vphy_released,
		.vphy_reset, .wake_pin_o, .wake_pin_oe, .wake_int_set);
	pwc_host_model u_pwc_host_model (.wake_pin_o, .wake_pin_oe,
		.pin_level);
	////////////////////////////////////////////////////////////////////
	task automatic chk(input pwc_word_t got, input pwc_word_t exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input pwc_word_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input pwc_word_t e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		chk(rv, e);
	endtask
	task automatic wait_int;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (wake_int_set !== 1'b1 && n < 20);
		chk(32'(wake_int_set), 32'h1);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdchk(A, 32'h0);
		device_ready <= 1'b1;
		wr(12'h088, 32'hFFFF_FFFF);
		rdchk(12'h088, 32'h0);
		rdchk(A, 32'h1);
		wr(A, 32'hFFFF_FFFF);
		rdchk(A, 32'h0000_C64F);
		chk(32'(vphy_reset), 32'h1);
		wr(A, 32'h0);
		rdchk(A, 32'h0000_0401);
		chk(32'(vphy_reset), 32'h1);
		@(posedge clk);
		vphy_released <= 1'b1;
		@(posedge clk);
		vphy_released <= 1'b0;
		rdchk(A, 32'h1);
		chk(32'(vphy_reset), 32'h0);
		$display("test regs done");
	endtask
	task automatic t_ed;
		for (pi = 0; pi < 2; pi++) begin
			wr(A, 32'h0000_C04E);
			// event stands for a phy with energy powerdown set
			ev[pi] <= 1'b1;
			wait_int();
			rdchk(A, 32'h0000_C04F | (32'h1 << (16 + pi)));
			chk({30'h0, wake_pin_oe, wake_pin_o}, 32'h3);
			wr(A, 32'h0003_C04E);
			rdchk(A, 32'h0000_C04F | (32'h1 << (16 + pi)));
			ev[pi] <= 1'b0;
			repeat (4) @(posedge clk);
			wr(A, 32'h0003_C04E);
			rdchk(A, 32'h0000_C04F);
			chk({30'h0, wake_pin_oe, wake_pin_o}, 32'h2);
		end
		$display("test energy done");
	endtask
	task automatic t_wol;
		int k;
		wr(A, 32'h0000_0200);
		ev[2] <= 1'b1;
		wait_int();
		chk(32'(pin_level), 32'h1);
		wr(A, 32'h0000_0220);
		rdchk(A, 32'h0000_0221);
		ev[2] <= 1'b0;
		repeat (4) @(posedge clk);
		wr(A, 32'h0000_0020);
		wr(A, 32'h0000_0202);
		ev[2] <= 1'b1;
		wait_int();
		k = 0;
		while (pin_level !== 1'b0 && k < 10) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(32'(wake_pin_o), 32'h0);
		k = 0;
		while (pin_level === 1'b0 && k < 100) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(32'(k), PC);
		ev[2] <= 1'b0;
		$display("test net wake done");
	endtask
	task automatic t_soft;
		wr(A, 32'h0000_024E);
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		rdchk(A, 32'h0000_0045);
		chk({30'h0, wake_pin_oe, wake_pin_o}, 32'h2);
		wr(A, 32'h0000_0040);
		rdchk(A, 32'h0000_0041);
		chk({30'h0, wake_pin_oe, wake_pin_o}, 32'h3);
		$display("test soft reset done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#(5 * 5000);
		err_total++;
		$display("watchdog expired");
		final_report();
	end
	initial begin
		sys_rst = 1'b1;
		soft_rst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		ev = 3'h0;
		device_ready = 1'b0;
		vphy_released = 1'b0;
		err_total = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_ed();
		t_wol();
		t_soft();
		final_report();
	end
endmodule // test_wake_event_power_ctrl_reg
